// ### core/flash_pkg.sv
// shared constants and carrier types for the flash access and protection block
package flash_pkg;
  localparam int ARRAY_BYTES = 65536;         // total capacity
  localparam int WORD_BYTES = 4;
  localparam int WORDS = ARRAY_BYTES / WORD_BYTES;
  localparam int WADDR_W = 14;                // word address width
  localparam int BADDR_W = 16;                // byte address width
  localparam int BLOCK_BYTES = 1024;          // erase unit
  localparam int BLOCK_WORDS = BLOCK_BYTES / WORD_BYTES;
  localparam int BLOCK_LSB = 10;              // byte address bit of block number
  localparam int BLOCK_W = 6;
  localparam int PAIR_LSB = 11;               // byte address bit of pair number
  localparam int PAIR_W = 5;
  localparam int PAIRS = 32;
  localparam int BW_IN_BLOCK = 8;             // word index bits within a block
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  localparam logic [1:0] ATTR_RESET = 2'h0;

  // per-pair protection attribute
  typedef enum logic [1:0] {
    ATTR_OPEN = 2'h0,
    ATTR_READ_ONLY = 2'h1,
    ATTR_EXEC_ONLY = 2'h2
  } attr_t;

  // who is reading
  typedef enum logic [1:0] {
    SRC_FETCH = 2'h0,
    SRC_DATA = 2'h1,
    SRC_DEBUG = 2'h2
  } src_t;

  typedef struct packed {
    logic valid;
    src_t src;
    logic [BADDR_W-1:0] addr;
  } rd_req_t;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [31:0] data;
  } rd_rsp_t;

  typedef struct packed {
    logic valid;
    logic erase;                // 1 erase block, 0 program word
    logic [BADDR_W-1:0] addr;
    logic [31:0] data;
  } wr_req_t;
endpackage

// ### core/flash_prot_check.sv
// protection lookup for one access: attribute by pair, verdicts for read and modify
`timescale 1ns/1ps
module flash_prot_check (
  input wire logic [1:0] attr,     // attribute of the addressed pair
  input wire flash_pkg::src_t src, // read source
  output logic read_ok,            // read allowed
  output logic modify_ok           // erase or program allowed
);
  // execute-only serves fetches only; any protection blocks modification
  always_comb
  begin
    read_ok = (attr != flash_pkg::ATTR_EXEC_ONLY) || (src == flash_pkg::SRC_FETCH);
    modify_ok = (attr == flash_pkg::ATTR_OPEN);
  end
endmodule

// ### core/flash_block_erase_protect.sv
// flash array with block erase, word program and per-pair protection
// Functional notes
// - array holds 64 KB, processor addressable
// - reads complete in one cycle, no waits
// - each 1 KB block erases on its own
// - erased block reads back all ones
// - protection attribute kept per 2 KB pair
// - read-only pair refuses erase and program
// - execute-only pair refuses erase and program
// - execute-only pair answers instruction fetches only
`timescale 1ns/1ps
module flash_block_erase_protect (
  input wire logic clk,                    // system clock
  input wire logic rst,                    // async reset, active high
  input wire flash_pkg::rd_req_t rd_req,   // read request
  output flash_pkg::rd_rsp_t rd_rsp,       // read answer, next cycle
  input wire flash_pkg::wr_req_t wr_req,   // erase or program request
  output logic wr_busy,                    // erase in progress
  output logic wr_done,                    // modify finished, pulse
  output logic wr_refused,                 // modify refused, pulse
  input wire logic attr_we,                // attribute write strobe
  input wire logic [flash_pkg::PAIR_W-1:0] attr_pair, // pair to set
  input wire logic [1:0] attr_val          // new attribute
);
  typedef enum {ST_IDLE, ST_ERASE} state_t;

  logic [31:0] mem [flash_pkg::WORDS];
  logic [1:0] attr_q [flash_pkg::PAIRS];
  state_t state_q;
  logic [flash_pkg::BLOCK_W-1:0] eblk_q;
  logic [flash_pkg::BW_IN_BLOCK-1:0] ecnt_q;
  logic rd_ok;
  logic wr_ok;
  logic [flash_pkg::PAIR_W-1:0] rd_pair;
  logic [flash_pkg::PAIR_W-1:0] wr_pair;
  logic [flash_pkg::WADDR_W-1:0] rd_widx;
  logic [flash_pkg::WADDR_W-1:0] wr_widx;
  logic [flash_pkg::WADDR_W-1:0] er_widx;
  logic wr_take;

  // pair index straight from the upper address bits
  assign rd_pair = rd_req.addr[flash_pkg::BADDR_W-1:flash_pkg::PAIR_LSB];
  assign wr_pair = wr_req.addr[flash_pkg::BADDR_W-1:flash_pkg::PAIR_LSB];
  assign rd_widx = rd_req.addr[flash_pkg::BADDR_W-1:2];
  assign wr_widx = wr_req.addr[flash_pkg::BADDR_W-1:2];
  assign er_widx = {eblk_q, ecnt_q};
  assign wr_take = wr_req.valid && (state_q == ST_IDLE);
  assign wr_busy = (state_q == ST_ERASE);

  flash_prot_check u_rd_chk (
    .attr(attr_q[rd_pair]),
    .src(rd_req.src),
    .read_ok(rd_ok),
    .modify_ok()          // reads never modify
  );

  flash_prot_check u_wr_chk (
    .attr(attr_q[wr_pair]),
    .src(flash_pkg::SRC_DATA),
    .read_ok(),           // modify path only needs the modify verdict
    .modify_ok(wr_ok)
  );

  // attribute table, all pairs open after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < flash_pkg::PAIRS; i++)
        attr_q[i] <= flash_pkg::ATTR_RESET;
    end
    else if (attr_we)
      attr_q[attr_pair] <= attr_val;
  end

  // registered read port; denied reads return zero so nothing leaks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_rsp <= '0;
    else
    begin
      rd_rsp.valid <= rd_req.valid;
      rd_rsp.denied <= rd_req.valid && !rd_ok;
      rd_rsp.data <= (rd_req.valid && rd_ok) ? mem[rd_widx] : 32'h0000_0000;
    end
  end

  // erase walks one word per cycle through the selected block only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      eblk_q <= '0;
      ecnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (wr_take && wr_req.erase && wr_ok)
          begin
            state_q <= ST_ERASE;
            eblk_q <= wr_req.addr[flash_pkg::BADDR_W-1:flash_pkg::BLOCK_LSB];
            ecnt_q <= '0;
          end
        end
        ST_ERASE:
        begin
          ecnt_q <= ecnt_q + 1'b1;
          if (ecnt_q == '1)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // array writes: erase fills ones, program clears bits like real flash
  always_ff @(posedge clk)
  begin
    if (state_q == ST_ERASE)
      mem[er_widx] <= flash_pkg::ERASED_WORD;
    else if (wr_take && !wr_req.erase && wr_ok)
      mem[wr_widx] <= mem[wr_widx] & wr_req.data;
  end

  // completion and refusal pulses
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_done <= 1'b0;
      wr_refused <= 1'b0;
    end
    else
    begin
      wr_done <= ((state_q == ST_ERASE) && (ecnt_q == '1))
        || (wr_take && !wr_req.erase && wr_ok);
      wr_refused <= wr_take && !wr_ok;
    end
  end

  // busy span measured apart from the walk counter, so a counter slip shows up
  logic [8:0] busy_len_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_len_q <= '0;
    else if (wr_busy)
      busy_len_q <= busy_len_q + 9'h001;
    else
      busy_len_q <= '0;
  end

  // erase walk: busy from the cycle after the start, done after the last word
  sequence s_erase_walk;
    wr_busy [*8] ##249 (wr_done && !wr_busy);
  endsequence

  // modify aimed at a read-only pair while the engine is free
  sequence s_ro_modify;
    state_q == ST_IDLE && wr_req.valid
      && attr_q[wr_pair] == flash_pkg::ATTR_READ_ONLY;
  endsequence

  // read that the attribute lets through
  sequence s_allowed_read;
    rd_req.valid && (attr_q[rd_pair] != flash_pkg::ATTR_EXEC_ONLY
      || rd_req.src == flash_pkg::SRC_FETCH);
  endsequence

  // program into an open pair while the engine is free
  sequence s_open_program;
    state_q == ST_IDLE && wr_req.valid && !wr_req.erase
      && attr_q[wr_pair] == flash_pkg::ATTR_OPEN;
  endsequence

  sequence s_exec_data_read;
    rd_req.valid && rd_req.src != flash_pkg::SRC_FETCH
      && attr_q[rd_pair] == flash_pkg::ATTR_EXEC_ONLY;
  endsequence

  sequence s_erase_start;
    state_q == ST_IDLE && wr_req.valid && wr_req.erase && wr_ok;
  endsequence

  a_read_one_cycle: assert property (@(posedge clk) disable iff (rst)
    rd_req.valid |=> rd_rsp.valid)
    else $error("read answer not in one cycle");
  a_exec_deny: assert property (@(posedge clk) disable iff (rst)
    s_exec_data_read |=> rd_rsp.denied && rd_rsp.data == 32'h0000_0000)
    else $error("execute-only data read not denied");
  a_fetch_allowed: assert property (@(posedge clk) disable iff (rst)
    rd_req.valid && rd_req.src == flash_pkg::SRC_FETCH |=> !rd_rsp.denied)
    else $error("fetch wrongly denied");
  a_prot_refuse: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_IDLE && wr_req.valid && attr_q[wr_pair] != flash_pkg::ATTR_OPEN
      |=> wr_refused && state_q == ST_IDLE)
    else $error("protected modify not refused");
  a_erase_length: assert property (@(posedge clk) disable iff (rst)
    s_erase_start |=> s_erase_walk)
    else $error("erase length wrong");
  a_erase_ones: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ERASE |=> mem[$past(er_widx)] == flash_pkg::ERASED_WORD)
    else $error("erased word not all ones");
  a_erase_block: assert property (@(posedge clk) disable iff (rst)
    s_erase_start |=> eblk_q == $past(wr_req.addr[15:10]))
    else $error("wrong block erased");
  a_pair_attr: assert property (@(posedge clk) disable iff (rst)
    attr_we |=> attr_q[$past(attr_pair)] == $past(attr_val))
    else $error("pair attribute not stored");
  a_exec_no_erase: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_IDLE && wr_req.valid && attr_q[wr_pair] == flash_pkg::ATTR_EXEC_ONLY
      |=> !wr_busy)
    else $error("execute-only pair modified");

  // read-only refusal, then what protection must let through, then erase block and span
  a_ro_no_erase: assert property (@(posedge clk) disable iff (rst)
    s_ro_modify |=> !wr_busy && !wr_done)
    else $error("read-only pair modified");
  a_read_allowed: assert property (@(posedge clk) disable iff (rst)
    s_allowed_read |=> rd_rsp.valid && !rd_rsp.denied)
    else $error("allowed read denied");
  a_open_program: assert property (@(posedge clk) disable iff (rst)
    s_open_program |=> wr_done && !wr_refused && !wr_busy)
    else $error("open pair program not done");
  a_block_held: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ERASE |=> $stable(eblk_q))
    else $error("erase block changed mid-erase");
  a_busy_ends_done: assert property (@(posedge clk) disable iff (rst)
    $fell(wr_busy) |-> wr_done && busy_len_q == 9'(flash_pkg::BLOCK_WORDS))
    else $error("erase span wrong at its end");
endmodule

// ### dv/flash_bus_model.sv
// processor and debug side model: issues reads and modify requests
`timescale 1ns/1ps
module flash_bus_model (
  input wire logic clk, // system clock
  input wire logic wr_done, // modify finished
  input wire logic wr_refused, // modify refused
  output flash_pkg::rd_req_t rd_req, // read request
  output flash_pkg::wr_req_t wr_req // modify request
);
  // quiet bus from time zero
  initial
  begin
    rd_req = '0;
    wr_req = '0;
  end
  // one read per edge; caller sits on an edge, so reads run back to back
  task automatic rd(input flash_pkg::src_t s, input logic [15:0] a);
    rd_req <= '{1'b1, s, a};
    @(posedge clk);
  endtask
  task automatic idle();
    rd_req <= '0;
    @(posedge clk);
  endtask
  // held for its taken edge only, then a bounded wait for the outcome;
  // the one-cycle pulses are read at the edge that samples them
  task automatic wr(input logic er, input logic [15:0] a, input logic [31:0] d);
    int i;
    wr_req <= '{1'b1, er, a, d};
    @(posedge clk);
    wr_req <= '0;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (i < 300 && wr_done !== 1'b1 && wr_refused !== 1'b1);
  endtask
endmodule

// ### dv/tb_top.sv
// self-checking bench: erase, program, protection and read sources
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, attr_we, wr_busy, wr_done, wr_refused, last_rd;
  logic [4:0] attr_pair;
  logic [1:0] attr_val;
  logic [9:0] busy_cnt;
  logic [31:0] d, w;
  logic [15:0] a;
  logic [33:0] rq[$];
  logic [11:0] wq[$];
  flash_pkg::rd_req_t rd_req;
  flash_pkg::rd_rsp_t rd_rsp;
  flash_pkg::wr_req_t wr_req;
  int num_errors, checked;
  int seed = 32'hA18F4337;
  flash_block_erase_protect DUT (.clk(clk), .rst(rst), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .wr_req(wr_req), .wr_busy(wr_busy), .wr_done(wr_done), .wr_refused(wr_refused),
    .attr_we(attr_we), .attr_pair(attr_pair), .attr_val(attr_val));
  flash_bus_model host (.clk(clk), .wr_done(wr_done), .wr_refused(wr_refused),
    .rd_req(rd_req), .wr_req(wr_req));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // notes go in before the request so the watcher never runs ahead
  task automatic op(input logic er, input logic [15:0] ad, input logic [31:0] dt,
    input logic [11:0] e);
    wq.push_back(e);
    host.wr(er, ad, dt);
  endtask
  task automatic rd(input int s, input logic [15:0] ad, input logic [33:0] e);
    rq.push_back(e);
    host.rd(flash_pkg::src_t'(s), ad);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog, generous against about 2400 cycles of work
  initial
  begin
    #200000;
    num_errors++;
    conclude();
  end
  // scoreboard: oldest note against each answer as it appears
  always @(posedge clk)
  begin
    if (rst)
    begin
      busy_cnt <= '0;
      last_rd <= 1'b0;
    end
    else
    begin
      last_rd <= rd_req.valid;
      chk(rd_rsp.valid, last_rd);
      if (wr_busy === 1'b1)
        busy_cnt <= busy_cnt + 10'h1;
      if (rd_rsp.valid === 1'b1)
        chk(rd_rsp, rq.pop_front());
      if (wr_done === 1'b1 || wr_refused === 1'b1)
      begin
        chk({wr_done, wr_refused, busy_cnt}, wq.pop_front());
        busy_cnt <= '0;
      end
    end
  end
  // main sequence; array is unknown until erased, so erase pairs 0..3 first
  initial
  begin
    rst = 1'b1;
    attr_we = 1'b0;
    attr_pair = 5'h00;
    attr_val = 2'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int b = 0; b < 8; b++)
      op(1'b1, 16'(b << 10), 32'h0, 12'h900);
    d = $random(seed);
    w = $random(seed);
    a = {6'h00, w[9:2], 2'h0};
    op(1'b0, a, d, 12'h800);
    op(1'b0, a, w, 12'h800);
    op(1'b1, 16'h0400, 32'h0, 12'h900);
    rd(1, a, {2'h2, d & w});
    rd(1, {6'h01, a[9:0]}, {2'h2, 32'hFFFFFFFF});
    host.idle();
    for (int p = 1; p < 4; p++)
    begin
      attr_pair <= 5'(p);
      attr_val <= 2'(p);
      attr_we <= 1'b1;
      @(posedge clk);
    end
    attr_we <= 1'b0;
    @(posedge clk);
    // second block of each pair, so one attribute must cover both
    for (int p = 1; p < 4; p++)
    begin
      op(1'b1, 16'((p << 11) | 16'h0400), 32'h0, 12'h400);
      op(1'b0, 16'(p << 11), 32'h0, 12'h400);
    end
    for (int p = 0; p < 4; p++)
      for (int s = 0; s < 3; s++)
        rd(s, 16'((p << 11) | 16'h07FC), (p == 2 && s != 0) ? {2'h3, 32'h0} :
          {2'h2, 32'hFFFFFFFF});
    host.idle();
    repeat (4) @(posedge clk);
    chk(rq.size() + wq.size(), 0);
    conclude();
  end
endmodule
